//--- shared/btif_pkg.sv
package btif_pkg;
  // 1.544 Mbit/s frame geometry
  localparam int BTIF_CHANNELS = 24;
  localparam int BTIF_BITS_PER_BYTE = 8;
  localparam int BTIF_FRAME_BITS = 193;
  localparam int BTIF_FRAMES_PER_SF = 12;
  // 2.048 Mbit/s frame geometry
  localparam int BTIF_E1_SLOTS = 32;
  localparam int BTIF_GROUP_BYTES = 4;
  // alignment options
  localparam logic [1:0] BTIF_ALIGN_FRAME = 2'h0;
  localparam logic [1:0] BTIF_ALIGN_SF = 2'h1;
  localparam logic [1:0] BTIF_ALIGN_2SF = 2'h2;
  // word carried through the fifo: pcm, negative rail, signalling, framing-bit flag, superframe start
  localparam int BTIF_WORD_W = 5;
  localparam int BTIF_FIFO_DEPTH = 4;
endpackage

//--- tb/btif_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// port relations of the transmit backplane block
// ****
module btif_assertions (
  input wire logic clk_sys_i, rstn_i, rate_2048_i, dual_rail_i, tx_ready_i, tx_valid_o, // controls
  input wire logic backplane_tx_clock, tx_pcm_o, tx_neg_o, tx_fbit_o, tx_sf_start_o, overflow_o, // bits
  input wire logic [4:0] tx_channel_o // channel
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  property p_chan; tx_valid_o |-> tx_channel_o <= 5'h18; endproperty
  a_chan: assert property (p_chan) else $error("channel out of range");
  property p_fbit; tx_valid_o && tx_fbit_o |-> tx_channel_o == 5'h18 && !rate_2048_i; endproperty
  a_fbit: assert property (p_fbit) else $error("framing bit misplaced");
  property p_gap; tx_valid_o && rate_2048_i |-> !tx_fbit_o && !tx_neg_o && tx_channel_o < 5'h18; endproperty
  a_gap: assert property (p_gap) else $error("gapped stream malformed");
  property p_neg; tx_valid_o && !dual_rail_i |-> !tx_neg_o; endproperty
  a_neg: assert property (p_neg) else $error("negative rail without dual rail");
  property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable({tx_pcm_o, tx_neg_o, tx_channel_o}); endproperty
  a_hold: assert property (p_hold) else $error("word changed before taken");
  property p_lat; !rate_2048_i && $rose(backplane_tx_clock) |-> ##[3:6] tx_valid_o; endproperty
  a_lat: assert property (p_lat) else $error("sampled bit not presented");
  property p_sf; tx_valid_o && tx_sf_start_o |-> tx_channel_o == 5'h00 && !tx_fbit_o; endproperty
  a_sf: assert property (p_sf) else $error("superframe start misplaced");
  property p_rst; $rose(rstn_i) |-> !tx_valid_o && !overflow_o; endproperty
  a_rst: assert property (p_rst) else $error("outputs busy after reset");
  property p_ovf; overflow_o |=> overflow_o; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag dropped");
endmodule
bind btif_top btif_assertions chk_u (.*);
`default_nettype wire

//--- tb/btif_bp_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// backplane source, clock idle low between frames
// ****
module btif_bp_model (
  output logic bclk_o, // backplane clock
  output logic pcm_o, // pcm or positive rail
  output logic sig_o, // signalling or negative rail
  output logic fp_o // frame pulse
);
  initial {bclk_o, pcm_o, sig_o, fp_o} = 4'h0;
  function automatic logic [7:0] pcmb(int c); return 8'(c * 37 + 5); endfunction
  function automatic logic [7:0] sigb(int c); return 8'(c * 11 + 7); endfunction
  // starts on the marked bit so the block is aligned before any data
  task automatic send(input bit e1, input int n);
    int p, k;
    logic [7:0] pb, sb;
    for (int i = 0; i < n; i++)
    begin
      p = e1 ? (248 + i) % 256 : (192 + i) % 193;
      k = p / 8;
      pb = (e1 ? k % 4 == 3 : k == 24) ? 8'hff : pcmb(e1 ? k / 4 * 3 + k % 4 : k);
      sb = (e1 ? k % 4 == 3 : k == 24) ? 8'hff : sigb(e1 ? k / 4 * 3 + k % 4 : k);
      fp_o = p == (e1 ? 248 : 192);
      pcm_o = pb[7 - p % 8];
      sig_o = sb[7 - p % 8];
      #80 bclk_o = 1'b1;
      #80 bclk_o = 0;
    end
    pcm_o = ~pcm_o;
    sig_o = ~sig_o;
    fp_o = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/btif_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// stream bench
// ****
module btif_top_tb_top;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic rate = 1'b0, dual = 1'b0, ready = 1'b0;
  logic [1:0] mode = 2'h0;
  wire logic bclk, pcm, sig, fp, pcm_w, neg_w, fb_w, sf_w, val_w, ovf_w;
  wire logic [3:0] nib_w;
  wire logic [4:0] ch_w;
  int err_count = 0, total_checks = 0;
  logic [8:0] got[$];
  always #2.5 clk_sys_i = ~clk_sys_i;
  btif_bp_model bp_u (.bclk_o(bclk), .pcm_o(pcm), .sig_o(sig), .fp_o(fp));
  btif_top dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .rate_2048_i(rate), .dual_rail_i(dual),
    .align_mode_i(mode), .backplane_tx_clock(bclk), .backplane_tx_pcm_in(pcm), .backplane_tx_signalling_in(sig),
    .backplane_tx_frame_pulse(fp), .tx_pcm_o(pcm_w), .tx_neg_o(neg_w), .tx_sig_nibble_o(nib_w), .tx_fbit_o(fb_w),
    .tx_sf_start_o(sf_w), .tx_channel_o(ch_w), .tx_valid_o(val_w), .tx_ready_i(ready), .overflow_o(ovf_w));
  always @(posedge clk_sys_i)
    if (rstn_i && val_w && ready) got.push_back({pcm_w, neg_w, fb_w, sf_w, ch_w});
  task automatic chk(input logic [8:0] g, e);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic start(input logic r, d, input logic [1:0] m, input logic rdy);
    @(posedge clk_sys_i) #1;
    rstn_i = 1'b0;
    {rate, dual, mode, ready} = {r, d, m, rdy};
    repeat (5) @(posedge clk_sys_i);
    #1 rstn_i = 1'b1;
    got.delete();
  endtask
  // the first word of every run is sampled before alignment, so it is skipped
  task automatic frame(input logic e1);
    logic [7:0] pb, sb;
    logic [8:0] g;
    bp_u.send(e1, e1 ? 264 : 194);
    repeat (10) @(posedge clk_sys_i);
    #1 chk(9'(got.size()), e1 ? 9'h0c1 : 9'h0c2);
    for (int i = 0; i < (e1 ? 192 : 193); i++)
    begin
      pb = i < 192 ? bp_u.pcmb(i / 8) : 8'hff;
      sb = i < 192 ? bp_u.sigb(i / 8) : 8'hff;
      g = got[i + 1];
      if (mode != 2'h1)
        g[5] = 1'b0;
      chk(g, {pb[7 - i % 8], dual && !e1 && sb[7 - i % 8], i == 192, mode == 2'h1 && i == 0, 5'(i / 8)});
    end
    sb = bp_u.sigb(23);
    if (!dual || e1)
      chk(9'(nib_w), 9'(sb[3:0]));
  endtask
  task automatic t_single(); start(0, 0, 2'h0, 1); frame(0); endtask
  task automatic t_dual(); start(0, 1, 2'h1, 1); frame(0); endtask
  task automatic t_gap(); start(1, 1, 2'h2, 1); frame(1); endtask
  task automatic t_full();
    start(0, 0, 2'h0, 0);
    bp_u.send(0, 6);
    repeat (10) @(posedge clk_sys_i);
    #1 chk({7'h0, val_w, ovf_w}, 9'h003);
    ready = 1'b1;
    repeat (10) @(posedge clk_sys_i);
    // four stored words plus the output register drain; the sixth bit was lost
    #1 chk({8'(got.size()), val_w}, 9'h00a);
  endtask
  task automatic give_verdict();
    if (err_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    t_single();
    t_dual();
    t_gap();
    t_full();
    give_verdict();
  end
  initial
  begin
    #300000;
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire

//--- verilog/btif_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module btif_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys_i, // system clock
  input wire logic rstn_i, // async reset, active low
  input wire logic [WIDTH-1:0] in_data_i, // write data
  input wire logic in_valid_i, // write request
  output logic in_ready_o, // not full
  output logic [WIDTH-1:0] out_data_o, // read data, registered
  output logic out_valid_o, // not empty
  input wire logic out_ready_i // read accept
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] count;
  logic out_full;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  wire stored = (count != '0);
  wire load_out = stored && (!out_full || pop);

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = out_full;

  always_ff @(posedge clk_sys_i)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data_i;
  end

  // read data sits in a register so the far side sees a steady word
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_full <= 1'b0;
      out_data_o <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr[AW-1:0] == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (load_out)
      begin
        out_data_o <= mem[rd_ptr[AW-1:0]];
        rd_ptr <= (rd_ptr[AW-1:0] == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(load_out);
      if (load_out)
        out_full <= 1'b1;
      else if (pop)
        out_full <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- verilog/btif_top.sv
`timescale 1ns/10ps
`default_nettype none
module btif_top
  import btif_pkg::*;
#(
  parameter int FIFO_DEPTH = BTIF_FIFO_DEPTH
) (
  input wire logic clk_sys_i, // 200 MHz system clock
  input wire logic rstn_i, // async reset, active low
  input wire logic rate_2048_i, // static: 1 = 2.048 Mbit/s backplane
  input wire logic dual_rail_i, // static: signalling pin carries negative rail (1.544 only)
  input wire logic [1:0] align_mode_i, // static: frame pulse option
  input wire logic backplane_tx_clock, // backplane transmit clock pin
  input wire logic backplane_tx_pcm_in, // pcm / positive rail pin
  input wire logic backplane_tx_signalling_in, // signalling / negative rail pin
  input wire logic backplane_tx_frame_pulse, // frame alignment pin
  output logic tx_pcm_o, // internal 1.544 stream bit (positive rail)
  output logic tx_neg_o, // negative rail bit, dual-rail at 1.544 only (held low at 2.048)
  output logic [3:0] tx_sig_nibble_o, // signalling nibble of the last completed channel byte
  output logic tx_fbit_o, // current bit is the framing bit
  output logic tx_sf_start_o, // first bit of a superframe (alignment frame)
  output logic [4:0] tx_channel_o, // channel index of current bit
  output logic tx_valid_o, // a bit is presented
  input wire logic tx_ready_i, // consumer takes the bit
  output logic overflow_o // sticky: bit lost because fifo was full
);
  // ************************************************************
  // input synchronisers and edge detect
  // ************************************************************
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic clk_d;
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1 <= '0;
      sync2 <= '0;
      clk_d <= 1'b0;
    end
    else
    begin
      sync1 <= {backplane_tx_clock, backplane_tx_pcm_in, backplane_tx_signalling_in, backplane_tx_frame_pulse};
      sync2 <= sync1;
      clk_d <= sync2[3];
    end
  end
  // sample on the rising backplane clock edge; data settles half a period before
  wire bp_edge = sync2[3] && !clk_d;
  wire pcm_s = sync2[2];
  wire sig_s = sync2[1];
  wire fp_s = sync2[0];

  // ************************************************************
  // frame position counters
  // ************************************************************
  logic [7:0] bit_pos; // 1.544: 0..192, 2.048: 0..255
  logic [3:0] frame_cnt;
  logic sf_odd;
  logic [7:0] sig_shift;
  wire [7:0] last_pos = rate_2048_i ? 8'(BTIF_E1_SLOTS * BTIF_BITS_PER_BYTE - 1) : 8'(BTIF_FRAME_BITS - 1);
  wire [7:0] fbit_pos = 8'(BTIF_CHANNELS * BTIF_BITS_PER_BYTE);
  wire [2:0] bit_in_byte = bit_pos[2:0];
  wire [4:0] byte_idx = bit_pos[7:3];
  wire [4:0] ds1_chan = rate_2048_i ? 5'((byte_idx >> 2) * 3 + byte_idx[1:0]) : byte_idx;
  wire is_filler = rate_2048_i && (byte_idx[1:0] == 2'(BTIF_GROUP_BYTES - 1));
  wire is_fbit = !rate_2048_i && (bit_pos == fbit_pos);
  wire last_frame = (frame_cnt == 4'(BTIF_FRAMES_PER_SF - 1));
  // in 2.048 mode the pulse arrives on the first filler bit of the last group
  wire [7:0] fp_pos = rate_2048_i ? 8'(BTIF_E1_SLOTS * BTIF_BITS_PER_BYTE - BTIF_BITS_PER_BYTE) : fbit_pos;
  wire [7:0] pos_after_fp = rate_2048_i ? fp_pos + 8'h01 : 8'h00;
  wire at_wrap = (bit_pos == last_pos);
  // with a superframe pulse the frame count is forced to the first frame (zero)
  wire align_sf = (align_mode_i != BTIF_ALIGN_FRAME);

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      bit_pos <= '0;
      frame_cnt <= '0;
      sf_odd <= 1'b0;
    end
    else if (bp_edge)
    begin
      if (fp_s)
      begin
        bit_pos <= pos_after_fp;
        frame_cnt <= align_sf ? '0 : (last_frame ? '0 : frame_cnt + 4'h1);
        sf_odd <= (align_mode_i == BTIF_ALIGN_2SF) ? 1'b0 : (last_frame ? !sf_odd : sf_odd);
      end
      else if (at_wrap)
      begin
        bit_pos <= '0;
        frame_cnt <= last_frame ? '0 : frame_cnt + 4'h1;
        if (last_frame)
          sf_odd <= !sf_odd;
      end
      else
        bit_pos <= bit_pos + 8'h01;
    end
  end

  // ************************************************************
  // signalling nibble capture, low four bits of each channel byte (filler bytes skipped)
  // ************************************************************
  logic [3:0] sig_nibble;
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sig_shift <= '0;
      sig_nibble <= '0;
    end
    else if (bp_edge)
    begin
      sig_shift <= {sig_shift[6:0], sig_s};
      if (bit_in_byte == 3'h7 && !is_filler && !is_fbit)
        sig_nibble <= {sig_shift[2:0], sig_s};
    end
  end

  // ************************************************************
  // gapped stream into the fifo
  // ************************************************************
  // filler bits are simply never pushed, which gaps the 2.048 clock
  wire push = bp_edge && !is_filler;
  wire neg_bit = dual_rail_i && !rate_2048_i && sig_s;
  wire pcm_bit = pcm_s;
  wire sf_mark = (frame_cnt == '0) && (bit_pos == '0) && (align_mode_i != BTIF_ALIGN_2SF || !sf_odd);
  wire [BTIF_WORD_W-1:0] in_word = {pcm_bit, neg_bit, sig_s, is_fbit, sf_mark};
  wire fifo_in_ready;
  wire [BTIF_WORD_W-1:0] out_word;

  btif_fifo #(
    .WIDTH(BTIF_WORD_W + 5),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .in_data_i({in_word, ds1_chan}),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .out_data_o({out_word, tx_channel_o}),
    .out_valid_o(tx_valid_o),
    .out_ready_i(tx_ready_i)
  );

  assign tx_pcm_o = out_word[4];
  assign tx_neg_o = out_word[3];
  assign tx_fbit_o = out_word[1];
  assign tx_sf_start_o = out_word[0];
  assign tx_sig_nibble_o = sig_nibble;

  // the backplane cannot be stalled, so a full fifo loses the bit and flags it
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      overflow_o <= 1'b0;
    else if (push && !fifo_in_ready)
      overflow_o <= 1'b1;
  end
endmodule
`default_nettype wire
